//--- verilog/pcw_top.sv
// counter array with 16-bit pwm modules and module 2 watchdog
`timescale 1ns/1ps
`include "pcw_cfg.svh"
module pcw_top #(
  parameter int NUM_MOD = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // array mode register write
  input wire logic md_wr_i,
  input wire logic md_wd_enable_i,
  input wire logic md_wd_lock_i,
  input wire logic [2:0] md_clk_sel_i,
  input wire logic md_idle_suspend_i,
  // module mode register writes
  input wire logic [NUM_MOD-1:0] mode_wr_i,
  input wire logic mode_cmp_en_i,
  input wire logic mode_pwm_en_i,
  input wire logic mode_pwm16_i,
  input wire logic mode_match_en_i,
  // compare byte writes
  input wire logic [NUM_MOD-1:0] cmp_low_wr_i,
  input wire logic [NUM_MOD-1:0] cmp_high_wr_i,
  input wire logic [7:0] cmp_wdata_i,
  // flag writes
  input wire logic ovf_flag_clr_i,
  input wire logic [NUM_MOD-1:0] match_flag_clr_i,
  input wire logic wd_force_i,
  // clock sources and idle
  input wire logic cpu_idle_i,
  input wire logic ext_tick_i,
  input wire logic ext_clk_pin_i,
  // module outputs
  output logic [NUM_MOD-1:0] module_output_pin_o,
  output logic [NUM_MOD-1:0] comparator_enable_o,
  output logic [NUM_MOD-1:0] module_match_flag_o,
  // array status
  output logic counter_overflow_flag_o,
  output logic [15:0] counter_o,
  output logic [2:0] counter_clock_select_o,
  output logic idle_suspend_o,
  // watchdog
  output logic watchdog_enabled_o,
  output logic watchdog_locked_o,
  output logic watchdog_reset_o
);
  localparam int WD = `PCW_WD_MOD;

  generate
    if (NUM_MOD < WD + 1 || NUM_MOD > 8) begin : g_bad_cfg
      $error("NUM_MOD must be 3 to 8, module 2 carries the watchdog");
    end
  endgenerate

  typedef struct packed {
    logic [15:0] cnt;
    logic ovf;
    logic [NUM_MOD-1:0] mflag;
    logic [NUM_MOD-1:0] cmp_en;
    logic [NUM_MOD-1:0] pwm_en;
    logic [NUM_MOD-1:0] pwm16;
    logic [NUM_MOD-1:0] match_en;
    logic [NUM_MOD-1:0][7:0] cmp_lo;
    logic [NUM_MOD-1:0][7:0] cmp_hi;
    pcw_pkg::pcw_wd_state_t wd;
    logic [2:0] clk_sel;
    logic idle_susp;
    logic wd_rst;
  } pcw_top_state_t;

  pcw_top_state_t r;
  pcw_top_state_t n;

  logic tick;
  logic cnt_run;
  logic wd_on;
  logic [15:0] cnt_nxt;
  logic [7:0] wd_reload;
  logic [NUM_MOD-1:0] mode_w;
  logic [NUM_MOD-1:0] match_w;
  logic [NUM_MOD-1:0] pin_w;
  logic [NUM_MOD-1:0][15:0] cmp_w;

  pcw_prescale u_prescale (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clk_sel_i(r.clk_sel),
    .ext_tick_i(ext_tick_i),
    .ext_pin_i(ext_clk_pin_i),
    .tick_o(tick)
  );

  assign wd_on = (r.wd != pcw_pkg::PCW_WD_OFF);
  assign cnt_run = tick & ~(r.idle_susp & cpu_idle_i);
  assign cnt_nxt = r.cnt + `PCW_CNT_STEP;
  // restart point: offset whole high-byte steps past the current high byte
  assign wd_reload = r.cnt[15:8] + r.cmp_lo[WD];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_MOD; gi++) begin : g_mod
      localparam bit IS_WD = (gi == WD);
      // module 2 serves the watchdog and drives no pwm while it runs
      assign mode_w[gi] = r.cmp_en[gi] & r.pwm_en[gi] & r.pwm16[gi]
                          & ~(IS_WD & wd_on);
      assign cmp_w[gi] = {r.cmp_hi[gi], r.cmp_lo[gi]};
      pcw_pwm16 u_pwm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(cnt_run),
        .cnt_nxt_i(cnt_nxt),
        .mode_i(mode_w[gi]),
        .cmp_i(cmp_w[gi]),
        .match_o(match_w[gi]),
        .pin_o(pin_w[gi])
      );
    end
  endgenerate

  always_comb begin
    n = r;
    n.wd_rst = 1'b0;
    if (cnt_run) begin
      n.cnt = cnt_nxt;
    end
    if (ovf_flag_clr_i) begin
      n.ovf = 1'b0;
    end
    if (cnt_run && r.cnt == `PCW_CNT_MAX) begin
      n.ovf = 1'b1;
    end
    for (int i = 0; i < NUM_MOD; i++) begin
      if (mode_wr_i[i]) begin
        n.cmp_en[i] = mode_cmp_en_i;
        n.pwm_en[i] = mode_pwm_en_i;
        n.pwm16[i] = mode_pwm16_i;
        n.match_en[i] = mode_match_en_i;
      end
      if (cmp_low_wr_i[i]) begin
        n.cmp_lo[i] = cmp_wdata_i;
        n.cmp_en[i] = 1'b0;
      end
      if (cmp_high_wr_i[i]) begin
        n.cmp_hi[i] = cmp_wdata_i;
        n.cmp_en[i] = 1'b1;
      end
      if (match_flag_clr_i[i]) begin
        n.mflag[i] = 1'b0;
      end
      // a match in the clearing cycle still lands
      if (match_w[i] && r.match_en[i]) begin
        n.mflag[i] = 1'b1;
      end
    end
    if (wd_on && cmp_high_wr_i[WD]) begin
      n.cmp_hi[WD] = wd_reload;
    end
    if (wd_force_i) begin
      if (wd_on) begin
        n.wd_rst = 1'b1;
      end else begin
        n.mflag[WD] = 1'b1;
      end
    end
    if (wd_on && cnt_run && r.cnt[7:0] == `PCW_BYTE_MAX && r.cnt[15:8] == r.cmp_hi[WD]) begin
      n.wd_rst = 1'b1;
    end
    if (md_wr_i) begin
      // source and idle choice are frozen by the running watchdog
      if (!wd_on) begin
        n.clk_sel = md_clk_sel_i;
        n.idle_susp = md_idle_suspend_i;
      end
      case (r.wd)
        pcw_pkg::PCW_WD_LOCK: begin
          n.wd = pcw_pkg::PCW_WD_LOCK;
        end
        default: begin
          if (md_wd_lock_i) begin
            n.wd = pcw_pkg::PCW_WD_LOCK;
          end else if (md_wd_enable_i) begin
            n.wd = pcw_pkg::PCW_WD_ON;
          end else begin
            n.wd = pcw_pkg::PCW_WD_OFF;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
      r.cnt <= `PCW_CNT_RST;
      r.wd <= pcw_pkg::PCW_WD_ON;
      r.clk_sel <= `PCW_SEL_DIV12;
      for (int i = 0; i < NUM_MOD; i++) begin
        r.cmp_lo[i] <= `PCW_BYTE_RST;
      end
    end else begin
      r <= n;
    end
  end

  assign module_output_pin_o = pin_w;
  assign comparator_enable_o = r.cmp_en;
  assign module_match_flag_o = r.mflag;
  assign counter_overflow_flag_o = r.ovf;
  assign counter_o = r.cnt;
  assign counter_clock_select_o = r.clk_sel;
  assign idle_suspend_o = r.idle_susp;
  // on and locked codes both carry bit 0, so each status output is a plain flop bit
  assign watchdog_enabled_o = r.wd[0];
  assign watchdog_locked_o = r.wd[1];
  assign watchdog_reset_o = r.wd_rst;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_pwm_rise: assert property (
    cnt_run && mode_w[0] && cnt_nxt == cmp_w[0] |=> module_output_pin_o[0])
    else $error("pwm output did not rise on compare match");

  chk_pwm_fall: assert property (
    cnt_run && mode_w[0] && cnt_nxt == `PCW_CNT_RST && cmp_w[0] != `PCW_CNT_RST
    |=> !module_output_pin_o[0])
    else $error("pwm output did not fall on counter wrap");

  chk_full_duty: assert property (
    mode_w[1] && cmp_w[1] == `PCW_CNT_RST && module_output_pin_o[1]
    ##1 mode_w[1] && cmp_w[1] == `PCW_CNT_RST |=> module_output_pin_o[1])
    else $error("compare zero let the pwm output drop");

  chk_mode_gate: assert property (
    !mode_w[0] |=> !module_output_pin_o[0] [*2] or mode_w[0])
    else $error("pwm output high outside 16-bit pwm mode");

  chk_match_flag: assert property (
    cnt_run && mode_w[0] && r.match_en[0] && cnt_nxt == cmp_w[0]
    |=> module_match_flag_o[0] && module_output_pin_o[0])
    else $error("match flag not set with the rising edge");

  chk_ovf_flag: assert property (
    cnt_run && counter_o == `PCW_CNT_MAX |=> counter_overflow_flag_o
    && counter_o == `PCW_CNT_RST)
    else $error("overflow flag not set on counter wrap");

  chk_cmp_low_clr: assert property (
    cmp_low_wr_i[0] && !cmp_high_wr_i[0] |=> !comparator_enable_o[0]
    ##1 !module_output_pin_o[0])
    else $error("compare low write left comparator enabled");

  chk_cmp_high_set: assert property (
    cmp_high_wr_i[0] |=> comparator_enable_o[0])
    else $error("compare high write did not enable comparator");

  chk_wd_fire: assert property (
    wd_on && cnt_run && counter_o[7:0] == `PCW_BYTE_MAX
    && counter_o[15:8] == r.cmp_hi[WD] |=> watchdog_reset_o)
    else $error("watchdog missed its timeout");

  chk_wd_quiet: assert property (
    !wd_on |=> !watchdog_reset_o)
    else $error("watchdog reset while disabled");

  chk_wd_reload: assert property (
    wd_on && cmp_high_wr_i[WD] |=> r.cmp_hi[WD] == $past(wd_reload))
    else $error("watchdog restart loaded the wrong match byte");

  chk_wd_force: assert property (
    wd_on && wd_force_i |=> watchdog_reset_o)
    else $error("forced watchdog reset not issued");

  chk_sel_frozen: assert property (
    wd_on |=> $stable(counter_clock_select_o) && $stable(idle_suspend_o))
    else $error("clock select or idle choice changed while enabled");

  chk_lock_hold: assert property (
    watchdog_locked_o |=> watchdog_locked_o && watchdog_enabled_o)
    else $error("locked watchdog was disabled");

  chk_reset_state: assert property (
    $fell(rst_i) |-> watchdog_enabled_o && counter_clock_select_o == `PCW_SEL_DIV12
    && r.cmp_lo[WD] == `PCW_BYTE_RST)
    else $error("watchdog not armed with defaults after reset");

  chk_idle_stop: assert property (
    idle_suspend_o && cpu_idle_i |=> $stable(counter_o))
    else $error("counter advanced during suspended idle");

  chk_count_step: assert property (
    cnt_run |=> counter_o == $past(cnt_nxt))
    else $error("counter did not step by one");

  cov_pwm_cycle: cover property (
    module_output_pin_o[0] ##1 !module_output_pin_o[0]);
  cov_wd_timeout: cover property (watchdog_reset_o && !$past(wd_force_i));
  cov_wd_force: cover property (wd_on && wd_force_i);
  cov_wd_lock: cover property (watchdog_locked_o);
endmodule

//--- verilog/pcw_cfg.svh
// named constants for the counter array pwm and watchdog block
`ifndef PCW_CFG_SVH
`define PCW_CFG_SVH
`define PCW_DIV_LAST 4'hb
`define PCW_DIV_ZERO 4'h0
`define PCW_DIV_STEP 4'h1
`define PCW_DIV4_PHASE 2'h3
`define PCW_SEL_DIV12 3'h0
`define PCW_SEL_DIV4 3'h1
`define PCW_SEL_TICK 3'h2
`define PCW_SEL_PIN 3'h3
`define PCW_SEL_SYS 3'h4
`define PCW_CNT_RST 16'h0000
`define PCW_CNT_MAX 16'hffff
`define PCW_CNT_STEP 16'h0001
`define PCW_BYTE_RST 8'h00
`define PCW_BYTE_MAX 8'hff
`define PCW_WD_MOD 2
`endif

//--- verilog/pcw_pkg.sv
// shared types for the counter array pwm and watchdog block
package pcw_pkg;
  // gray along off -> on -> locked
  typedef enum logic [1:0] {
    PCW_WD_OFF = 2'h0,
    PCW_WD_ON = 2'h1,
    PCW_WD_LOCK = 2'h3
  } pcw_wd_state_t;
endpackage

//--- verilog/pcw_prescale.sv
// counter clock source selection as a one-cycle tick
`timescale 1ns/1ps
`include "pcw_cfg.svh"
module pcw_prescale (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // source select
  input wire logic [2:0] clk_sel_i,
  input wire logic ext_tick_i,
  input wire logic ext_pin_i,
  // tick out
  output logic tick_o
);
  typedef struct packed {
    logic [3:0] div;
    logic s1;
    logic s2;
    logic s3;
  } pcw_pre_state_t;

  pcw_pre_state_t r;
  pcw_pre_state_t n;

  always_comb begin
    n = r;
    n.div = (r.div == `PCW_DIV_LAST) ? `PCW_DIV_ZERO : r.div + `PCW_DIV_STEP;
    n.s1 = ext_pin_i;
    n.s2 = r.s1;
    n.s3 = r.s2;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // /4 taps the same divider so both rates stay evenly spaced
  always_comb begin
    case (clk_sel_i)
      `PCW_SEL_DIV12: tick_o = (r.div == `PCW_DIV_LAST);
      `PCW_SEL_DIV4: tick_o = (r.div[1:0] == `PCW_DIV4_PHASE);
      `PCW_SEL_TICK: tick_o = ext_tick_i;
      `PCW_SEL_PIN: tick_o = r.s3 & ~r.s2;
      `PCW_SEL_SYS: tick_o = 1'b1;
      default: tick_o = 1'b0;
    endcase
  end
endmodule

//--- verilog/pcw_pwm16.sv
// one capture/compare module in 16-bit pwm mode
`timescale 1ns/1ps
`include "pcw_cfg.svh"
module pcw_pwm16 (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // counter view
  input wire logic tick_i,
  input wire logic [15:0] cnt_nxt_i,
  // module setup
  input wire logic mode_i,
  input wire logic [15:0] cmp_i,
  // results
  output logic match_o,
  output logic pin_o
);
  typedef struct packed {
    logic pin;
  } pcw_pwm_state_t;

  pcw_pwm_state_t r;
  pcw_pwm_state_t n;

  assign match_o = tick_i & mode_i & (cnt_nxt_i == cmp_i);
  assign pin_o = r.pin;

  always_comb begin
    n = r;
    if (!mode_i) begin
      n.pin = 1'b0;
    end else if (match_o) begin
      // match beats the wrap, so compare zero never drops the output
      n.pin = 1'b1;
    end else if (tick_i && cnt_nxt_i == `PCW_CNT_RST) begin
      n.pin = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

//--- verif/tb.sv
// self-checking bench for the counter array pwm and watchdog block
`timescale 1ns/1ps
module tb;
  localparam int NM = 3;
  logic clk_i, rst_i, md_wr_i, md_en, md_lk, md_idl, ovf_clr, wd_force, cpu_idle;
  logic m_cen, m_pwm, m_p16, m_men;
  logic [2:0] md_sel;
  logic [NM-1:0] mode_wr, lo_wr, hi_wr, mf_clr, pin_o, cen_o, mflag_o;
  logic [7:0] wdata;
  logic [15:0] cnt_o;
  logic [2:0] sel_o;
  logic ovf_o, idle_o, wden_o, wdlk_o, wdrst_o;
  int error_cnt = 0;
  int samples_checked = 0;

  pcw_top #(.NUM_MOD(NM)) pcw_top_inst (
    .clk_i(clk_i), .rst_i(rst_i),
    .md_wr_i(md_wr_i), .md_wd_enable_i(md_en), .md_wd_lock_i(md_lk),
    .md_clk_sel_i(md_sel), .md_idle_suspend_i(md_idl),
    .mode_wr_i(mode_wr), .mode_cmp_en_i(m_cen), .mode_pwm_en_i(m_pwm),
    .mode_pwm16_i(m_p16), .mode_match_en_i(m_men),
    .cmp_low_wr_i(lo_wr), .cmp_high_wr_i(hi_wr), .cmp_wdata_i(wdata),
    .ovf_flag_clr_i(ovf_clr), .match_flag_clr_i(mf_clr), .wd_force_i(wd_force),
    .cpu_idle_i(cpu_idle), .ext_tick_i(1'b0), .ext_clk_pin_i(1'b0),
    .module_output_pin_o(pin_o), .comparator_enable_o(cen_o),
    .module_match_flag_o(mflag_o), .counter_overflow_flag_o(ovf_o),
    .counter_o(cnt_o), .counter_clock_select_o(sel_o), .idle_suspend_o(idle_o),
    .watchdog_enabled_o(wden_o), .watchdog_locked_o(wdlk_o),
    .watchdog_reset_o(wdrst_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // all driving and sampling happens 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic do_reset();
    rst_i = 1'b1;
    cyc(8);
    rst_i = 1'b0;
  endtask

  task automatic md(input logic en, input logic lk, input logic [2:0] sel, input logic idl);
    {md_en, md_lk, md_sel, md_idl} = {en, lk, sel, idl};
    md_wr_i = 1'b1;
    cyc(1);
    md_wr_i = 1'b0;
    cyc(1);
  endtask

  task automatic cw(input int m, input logic hi, input logic [7:0] d);
    wdata = d;
    if (hi) hi_wr[m] = 1'b1;
    else lo_wr[m] = 1'b1;
    cyc(1);
    hi_wr = '0;
    lo_wr = '0;
    cyc(1);
  endtask

  task automatic mode(input logic [NM-1:0] w, input logic p16);
    {m_cen, m_pwm, m_p16, m_men} = {1'b1, 1'b1, p16, 1'b1};
    mode_wr = w;
    cyc(1);
    mode_wr = '0;
    cyc(1);
  endtask

  task automatic wait_wd(output int n);
    n = 0;
    while (wdrst_o !== 1'b1 && n < 5000) begin
      cyc(1);
      n++;
    end
  endtask

  initial begin
    #2200000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    int n, c, pc, lb, hb, off, ov;
    int e[2];
    int f[2];
    logic [15:0] cmp0;
    {md_wr_i, md_en, md_lk, md_idl, md_sel, ovf_clr, wd_force, cpu_idle} = '0;
    {m_cen, m_pwm, m_p16, m_men, mode_wr, lo_wr, hi_wr, mf_clr, wdata} = '0;
    rst_i = 1'b1;
    void'($urandom(44506));
    do_reset();
    chk(wden_o, 1);
    chk(sel_o, 0);
    chk(cnt_o, 0);
    // default timeout: 256 ticks of sysclk/12
    wait_wd(n);
    chk(n >= 3070 && n <= 3076, 1);
    chk(cnt_o, 16'h0100);
    do_reset();
    // disabling write carries a clock and idle choice that must be dropped
    md(1'b0, 1'b0, 3'h4, 1'b1);
    chk(wden_o, 0);
    chk(sel_o, 0);
    chk(idle_o, 0);
    md(1'b0, 1'b0, 3'h4, 1'b1);
    chk(sel_o, 4);
    chk(idle_o, 1);
    cpu_idle = 1'b1;
    cyc(2);
    c = cnt_o;
    cyc(20);
    chk(cnt_o, c);
    cpu_idle = 1'b0;
    cyc(3);
    c = cnt_o;
    cyc(10);
    chk(cnt_o, (c + 10) & 16'hffff);
    md(1'b0, 1'b0, 3'h4, 1'b0);
    // module 0 random compare, module 1 compare zero, module 2 not in 16-bit mode
    cmp0 = 16'h1000 + 16'($urandom_range(16'hdfff));
    mode(3'b011, 1'b1);
    mode(3'b100, 1'b0);
    cw(0, 1'b0, cmp0[7:0]);
    chk(cen_o[0], 0);
    cw(0, 1'b1, cmp0[15:8]);
    chk(cen_o[0], 1);
    cw(1, 1'b0, 8'h00);
    cw(1, 1'b1, 8'h00);
    cw(2, 1'b0, 8'h00);
    cw(2, 1'b1, 8'h00);
    ovf_clr = 1'b1;
    mf_clr = '1;
    cyc(1);
    ovf_clr = 1'b0;
    mf_clr = '0;
    e = '{-1, -1};
    f = '{0, 0};
    ov = 0;
    pc = cnt_o;
    for (int i = 0; i < 70000; i++) begin
      cyc(1);
      c = cnt_o;
      chk(c, (pc + 1) & 16'hffff);
      pc = c;
      for (int m = 0; m < 2; m++) begin
        if (c == (m == 0 ? int'(cmp0) : 0)) begin
          e[m] = 1;
          f[m] = 1;
        end else if (c == 0) begin
          e[m] = 0;
        end
        if (e[m] >= 0) chk(pin_o[m], e[m]);
        chk(mflag_o[m], f[m]);
      end
      chk(pin_o[2], 0);
      if (c == 0) ov = 1;
      chk(ovf_o, ov);
    end
    // module 1 is steadily high; dropping its comparator must force it low
    cw(1, 1'b0, 8'h00);
    chk(cen_o[1], 0);
    repeat (5) begin
      cyc(1);
      chk(pin_o[1], 0);
    end
    // retune module 0 64 counts ahead, then again right after its match flag, low byte then high byte
    c = (cnt_o + 64) & 16'hffff;
    cw(0, 1'b0, 8'(c));
    cw(0, 1'b1, 8'(c >> 8));
    for (int k = 0; k < 2; k++) begin
      mf_clr = 3'h1;
      cyc(1);
      mf_clr = '0;
      n = 0;
      while (mflag_o[0] !== 1'b1 && n < 200) begin
        cyc(1);
        n++;
      end
      chk(cnt_o, c);
      chk(pin_o[0], 1);
      if (k == 0) begin
        c = (cnt_o + 64) & 16'hffff;
        cw(0, 1'b0, 8'(c));
        chk(cen_o[0], 0);
        cw(0, 1'b1, 8'(c >> 8));
        chk(pin_o[0], 0);
      end
    end
    // watchdog set-up in the documented order, then a restart
    off = $urandom_range(3);
    cw(2, 1'b0, 8'(off));
    md(1'b1, 1'b0, 3'h4, 1'b0);
    chk(wden_o, 1);
    while (cnt_o[7:0] > 8'hf0) cyc(1);
    lb = cnt_o[7:0];
    hb = cnt_o[15:8];
    cw(2, 1'b1, 8'h5a);
    wait_wd(n);
    n = n + 2;
    c = 256 * off + 256 - lb;
    chk(n >= c - 3 && n <= c + 3, 1);
    chk(cnt_o[7:0], 0);
    chk(cnt_o[15:8], (hb + off + 1) & 255);
    cyc(2);
    chk(wdrst_o, 0);
    wd_force = 1'b1;
    cyc(1);
    wd_force = 1'b0;
    chk(wdrst_o, 1);
    md(1'b0, 1'b1, 3'h4, 1'b0);
    chk(wdlk_o, 1);
    chk(wden_o, 1);
    md(1'b0, 1'b0, 3'h4, 1'b0);
    chk(wden_o, 1);
    do_reset();
    chk(wdlk_o, 0);
    chk(wden_o, 1);
    give_verdict();
  end
endmodule
